/* File: hw/serial_bcd_rtc_core.v */
// Behaviour
// - Read pointer advances only on master acknowledge
// - Sequential reads continue until master non-acknowledge
// - Bare read starts at last stored pointer
// - First write byte is pointer, then data
// - Acknowledge address, word address, each data byte
// - Century flag toggles at rollover when enabled
// - Weekday 1..7 in low bits; date fields BCD
// - Halt bit stops timekeeping, zero resumes it
// - Tolerate oscillator start-up delay after halt release
// - Hold register update while reading, 250ms max
// - Open-drain output follows control bit 7
// - Oscillator fail flag set on any stop
// - Fail flag stays set until written zero
// - Power-up: output high, fail set, halt clear
// - Time fields counted in packed BCD ranges
// - Control register addressable alone and sequentially
// - Respond only to slave address D0h
// - Release data line after master non-acknowledge
`timescale 1ns/10ps
`include "rtc_map.vh"

module serial_bcd_rtc_core
#(
  parameter HOLD_CYCLES     = `HOLD_CYCLES,
  parameter OSC_LOSS_CYCLES = `OSC_LOSS_CYCLES,
  parameter STARTUP_TICKS   = `STARTUP_TICKS
)
(
  // Clock and reset
  input  wire I_CLOCK,
  input  wire I_RST,
  // Two-wire serial bus
  input  wire I_SCL,
  input  wire I_SDA,
  output wire O_SDA,
  output reg  O_SDA_OE,
  // 32768 Hz time base
  input  wire I_OSC,
  // Open-drain output pin
  output wire O_OUT,
  output reg  O_OUT_OE
);

  // --------------------------------------------------------------
  // Constants
  // --------------------------------------------------------------
  localparam PH_IDLE     = 3'd0;
  localparam PH_ADDR     = 3'd1;
  localparam PH_ADDR_ACK = 3'd2;
  localparam PH_RX       = 3'd3;
  localparam PH_RX_ACK   = 3'd4;
  localparam PH_TX       = 3'd5;
  localparam PH_TX_ACK   = 3'd6;
  localparam PH_WAIT     = 3'd7;

  localparam [24:0] HOLD_LAST     = HOLD_CYCLES - 1;
  localparam [15:0] LOSS_LAST     = OSC_LOSS_CYCLES - 1;
  localparam [16:0] STARTUP_COUNT = STARTUP_TICKS;

  // --------------------------------------------------------------
  // Input synchronisers and edge detection
  // --------------------------------------------------------------
  reg  [1:0] scl_sync;
  reg  [1:0] sda_sync;
  reg  [1:0] osc_sync;
  reg        scl_d;
  reg        sda_d;
  reg        osc_d;

  // Two flops per pin, then one delay stage for edges
  always @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
    begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
      osc_sync <= 2'b00;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
      osc_d    <= 1'b0;
    end
    else
    begin
      scl_sync <= {scl_sync[0], I_SCL};
      sda_sync <= {sda_sync[0], I_SDA};
      osc_sync <= {osc_sync[0], I_OSC};
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
      osc_d    <= osc_sync[1];
    end
  end

  wire scl        = scl_sync[1];
  wire sda        = sda_sync[1];
  wire scl_rise   = scl & ~scl_d;
  wire scl_fall   = ~scl & scl_d;
  wire start_cond = scl & scl_d & sda_d & ~sda;
  wire stop_cond  = scl & scl_d & ~sda_d & sda;
  wire osc_edge   = osc_sync[1] & ~osc_d;

  // --------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------
  reg         osc_halt;
  reg         osc_fail_flag;
  reg         out_level;
  reg  [55:0] shadow;
  reg  [2:0]  word_pointer_value;
  reg         wr_stb;
  reg  [2:0]  wr_idx;
  reg  [7:0]  wr_data;
  wire [6:0]  cal_sec;
  wire [6:0]  cal_min;
  wire [5:0]  cal_hour;
  wire        cal_century_toggle_enable;
  wire        cal_century_flag;
  wire [2:0]  cal_wday;
  wire [5:0]  cal_mday;
  wire [4:0]  cal_month;
  wire [7:0]  cal_year;
  wire [55:0] live = {cal_year, 3'h0, cal_month, 2'h0, cal_mday, 5'h00, cal_wday,
                      cal_century_toggle_enable, cal_century_flag, cal_hour,
                      1'b0, cal_min, 1'b0, cal_sec};
  reg  [7:0]  rd_byte;

  // Read view: time bytes from the shadow, flags and control live
  always @*
  begin
    case (word_pointer_value)
      `REG_SECONDS: rd_byte = {osc_halt, shadow[6:0]};
      `REG_MINUTES: rd_byte = {osc_fail_flag, shadow[14:8]};
      `REG_CONTROL: rd_byte = {out_level, 7'h00};
      default:      rd_byte = shadow[word_pointer_value * 8 +: 8];
    endcase
  end

  // --------------------------------------------------------------
  // Serial slave
  // --------------------------------------------------------------
  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] rx_shift;
  reg [7:0] tx_shift;
  reg       first_byte;
  reg       master_ack;

  assign O_SDA = 1'b0;

  // Bus protocol engine, open-drain data line
  always @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
    begin
      state              <= PH_IDLE;
      bit_cnt            <= 4'h0;
      rx_shift           <= 8'h00;
      tx_shift           <= 8'h00;
      first_byte         <= 1'b0;
      master_ack         <= 1'b0;
      word_pointer_value <= `REG_SECONDS;
      O_SDA_OE           <= 1'b0;
      wr_stb             <= 1'b0;
      wr_idx             <= 3'h0;
      wr_data            <= 8'h00;
    end
    else
    begin
      wr_stb <= 1'b0;
      if (start_cond)
      begin
        state    <= PH_ADDR;
        bit_cnt  <= 4'h0;
        O_SDA_OE <= 1'b0;
      end
      else if (stop_cond)
      begin
        state    <= PH_IDLE;
        O_SDA_OE <= 1'b0;
      end
      else
      begin
        case (state)
          PH_ADDR:
          begin
            if (scl_rise)
            begin
              rx_shift <= {rx_shift[6:0], sda};
              bit_cnt  <= bit_cnt + 4'h1;
            end
            else if (scl_fall && bit_cnt == 4'h8)
            begin
              if (rx_shift[7:1] == `RTC_SLAVE_ADDR)
              begin
                state    <= PH_ADDR_ACK;
                O_SDA_OE <= 1'b1;
              end
              else
                state <= PH_WAIT;
            end
          end
          PH_ADDR_ACK:
          begin
            if (scl_fall)
            begin
              bit_cnt <= 4'h0;
              if (rx_shift[0])
              begin
                // Read starts at the stored pointer
                state    <= PH_TX;
                tx_shift <= rd_byte;
                O_SDA_OE <= ~rd_byte[7];
              end
              else
              begin
                state      <= PH_RX;
                first_byte <= 1'b1;
                O_SDA_OE   <= 1'b0;
              end
            end
          end
          PH_RX:
          begin
            if (scl_rise)
            begin
              rx_shift <= {rx_shift[6:0], sda};
              bit_cnt  <= bit_cnt + 4'h1;
            end
            else if (scl_fall && bit_cnt == 4'h8)
            begin
              state    <= PH_RX_ACK;
              O_SDA_OE <= 1'b1;
              if (first_byte)
                word_pointer_value <= rx_shift[2:0];
              else
              begin
                wr_stb             <= 1'b1;
                wr_idx             <= word_pointer_value;
                wr_data            <= rx_shift;
                word_pointer_value <= word_pointer_value + 3'h1;
              end
            end
          end
          PH_RX_ACK:
          begin
            if (scl_fall)
            begin
              state      <= PH_RX;
              bit_cnt    <= 4'h0;
              first_byte <= 1'b0;
              O_SDA_OE   <= 1'b0;
            end
          end
          PH_TX:
          begin
            if (scl_rise)
              bit_cnt <= bit_cnt + 4'h1;
            else if (scl_fall)
            begin
              if (bit_cnt == 4'h8)
              begin
                state    <= PH_TX_ACK;
                O_SDA_OE <= 1'b0;
              end
              else
              begin
                tx_shift <= {tx_shift[6:0], 1'b0};
                O_SDA_OE <= ~tx_shift[6];
              end
            end
          end
          PH_TX_ACK:
          begin
            if (scl_rise)
            begin
              master_ack <= ~sda;
              if (!sda)
                word_pointer_value <= word_pointer_value + 3'h1;
            end
            else if (scl_fall)
            begin
              bit_cnt <= 4'h0;
              if (master_ack)
              begin
                state    <= PH_TX;
                tx_shift <= rd_byte;
                O_SDA_OE <= ~rd_byte[7];
              end
              else
                state <= PH_WAIT;
            end
          end
          PH_WAIT:  O_SDA_OE <= 1'b0;
          default:  O_SDA_OE <= 1'b0;
        endcase
      end
    end
  end

  // --------------------------------------------------------------
  // Read hold of the visible time registers
  // --------------------------------------------------------------
  reg  [24:0] hold_cnt;
  wire        reading = (state == PH_TX || state == PH_TX_ACK) &&
                        (word_pointer_value != `REG_CONTROL);
  wire        hold_done = (hold_cnt == HOLD_LAST);

  // Shadow follows the counters except during a read, 250ms at most
  always @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
    begin
      hold_cnt <= 25'h0000000;
      shadow   <= 56'h00000000000000;
    end
    else
    begin
      if (!reading || hold_done)
      begin
        shadow   <= live;
        hold_cnt <= 25'h0000000;
      end
      else
        hold_cnt <= hold_cnt + 25'h0000001;
    end
  end

  // --------------------------------------------------------------
  // Oscillator supervision and one-second divider
  // --------------------------------------------------------------
  reg  [15:0] loss_cnt;
  reg         osc_lost;
  reg  [16:0] startup_cnt;
  reg  [14:0] prescale;
  reg         tick;
  wire        run = ~osc_halt & ~osc_lost & (startup_cnt == 17'h00000);

  // Watchdog on oscillator edges, start-up wait, divide by 32768
  always @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
    begin
      loss_cnt    <= 16'h0000;
      osc_lost    <= 1'b0;
      startup_cnt <= 17'h00000;
      prescale    <= 15'h0000;
      tick        <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (osc_edge)
      begin
        loss_cnt <= 16'h0000;
        osc_lost <= 1'b0;
      end
      else if (loss_cnt == LOSS_LAST)
        osc_lost <= 1'b1;
      else
        loss_cnt <= loss_cnt + 16'h0001;
      if (osc_halt)
      begin
        startup_cnt <= STARTUP_COUNT;
        prescale    <= 15'h0000;
      end
      else if (osc_edge && startup_cnt != 17'h00000)
        startup_cnt <= startup_cnt - 17'h00001;
      else if (osc_edge && run)
      begin
        prescale <= prescale + 15'h0001;
        tick     <= (prescale == `OSC_DIV_LAST);
      end
    end
  end

  // --------------------------------------------------------------
  // Control bits and open-drain output
  // --------------------------------------------------------------
  wire ctl_wr  = wr_stb && wr_idx == `REG_CONTROL;
  wire sec_wr  = wr_stb && wr_idx == `REG_SECONDS;
  wire min_wr  = wr_stb && wr_idx == `REG_MINUTES;
  wire fail_ev = osc_halt | osc_lost;

  assign O_OUT = 1'b0;

  // Halt, fail flag and output level; a stop event beats a clear
  always @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
    begin
      osc_halt      <= `RST_OSC_HALT;
      osc_fail_flag <= `RST_OSC_FAIL;
      out_level     <= `RST_OUT_LEVEL;
      O_OUT_OE      <= 1'b0;
    end
    else
    begin
      if (sec_wr)
        osc_halt <= wr_data[`BIT_OSC_HALT];
      if (fail_ev)
        osc_fail_flag <= 1'b1;
      else if (min_wr)
        osc_fail_flag <= wr_data[`BIT_OSC_FAIL];
      if (ctl_wr)
        out_level <= wr_data[`BIT_OUT_LEVEL];
      O_OUT_OE <= ctl_wr ? ~wr_data[`BIT_OUT_LEVEL] : ~out_level;
    end
  end

  // --------------------------------------------------------------
  // Calendar counters
  // --------------------------------------------------------------
  bcd_calendar u_calendar
  (
    .i_clk       (I_CLOCK),
    .i_rst       (I_RST),
    .i_tick      (tick),
    .i_load      (wr_stb && wr_idx != `REG_CONTROL),
    .i_load_idx  (wr_idx),
    .i_load_data (wr_data),
    .o_sec       (cal_sec),
    .o_min       (cal_min),
    .o_hour      (cal_hour),
    .o_century_toggle_enable (cal_century_toggle_enable),
    .o_century_flag          (cal_century_flag),
    .o_wday      (cal_wday),
    .o_mday      (cal_mday),
    .o_month     (cal_month),
    .o_year      (cal_year)
  );

endmodule // serial_bcd_rtc_core

/* File: hw/rtc_map.vh */
`ifndef RTC_MAP_VH
`define RTC_MAP_VH

// ----------------------------------------------------------------
// Serial slave address and register pointer values
// ----------------------------------------------------------------
`define RTC_SLAVE_ADDR    7'h68
`define REG_SECONDS       3'h0
`define REG_MINUTES       3'h1
`define REG_HOURS         3'h2
`define REG_WEEKDAY       3'h3
`define REG_DAY_OF_MONTH  3'h4
`define REG_MONTH         3'h5
`define REG_YEAR          3'h6
`define REG_CONTROL       3'h7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_OSC_HALT      7
`define BIT_OSC_FAIL      7
`define BIT_CENTURY_EN    7
`define BIT_CENTURY       6
`define BIT_OUT_LEVEL     7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_OSC_HALT      1'b0
`define RST_OSC_FAIL      1'b1
`define RST_OUT_LEVEL     1'b1
`define RST_SECONDS       7'h00
`define RST_MINUTES       7'h00
`define RST_HOURS         6'h00
`define RST_WEEKDAY       3'h1
`define RST_DAY_OF_MONTH  6'h01
`define RST_MONTH         5'h01
`define RST_YEAR          8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS     8
`define OSC_DIV_LAST      15'h7fff
`define HOLD_MS           250
`define HOLD_CYCLES       (`HOLD_MS * 1000000 / `CLK_PERIOD_NS)
`define OSC_LOSS_US       122
`define OSC_LOSS_CYCLES   (`OSC_LOSS_US * 1000 / `CLK_PERIOD_NS)
`define STARTUP_TICKS     32768

`endif

/* File: hw/bcd_calendar.v */
`timescale 1ns/10ps
`include "rtc_map.vh"

module bcd_calendar
(
  // Clock and reset
  input  wire       i_clk,
  input  wire       i_rst,
  // One-second tick
  input  wire       i_tick,
  // Register load from the serial side
  input  wire       i_load,
  input  wire [2:0] i_load_idx,
  input  wire [7:0] i_load_data,
  // Counters
  output reg  [6:0] o_sec,
  output reg  [6:0] o_min,
  output reg  [5:0] o_hour,
  output reg        o_century_toggle_enable,
  output reg        o_century_flag,
  output reg  [2:0] o_wday,
  output reg  [5:0] o_mday,
  output reg  [4:0] o_month,
  output reg  [7:0] o_year
);

  // --------------------------------------------------------------
  // BCD helpers
  // --------------------------------------------------------------
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9)
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      else
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  wire       leap = o_year[4] ? (o_year[3:0] == 4'h2 || o_year[3:0] == 4'h6)
                              : (o_year[3:0] == 4'h0 || o_year[3:0] == 4'h4 ||
                                 o_year[3:0] == 4'h8);
  reg  [5:0] last_mday;
  wire [7:0] sec_inc   = bcd_inc({1'b0, o_sec});
  wire [7:0] min_inc   = bcd_inc({1'b0, o_min});
  wire [7:0] hour_inc  = bcd_inc({2'b00, o_hour});
  wire [7:0] mday_inc  = bcd_inc({2'b00, o_mday});
  wire [7:0] month_inc = bcd_inc({3'b000, o_month});
  wire [7:0] year_inc  = bcd_inc(o_year);
  wire       sec_end   = (o_sec == 7'h59);
  wire       min_end   = sec_end & (o_min == 7'h59);
  wire       hour_end  = min_end & (o_hour == 6'h23);
  wire       mday_end  = hour_end & (o_mday == last_mday);
  wire       month_end = mday_end & (o_month == 5'h12);
  wire       year_end  = month_end & (o_year == 8'h99);

  // Month length with leap years
  always @*
  begin
    case (o_month)
      5'h02:   last_mday = leap ? 6'h29 : 6'h28;
      5'h04,
      5'h06,
      5'h09,
      5'h11:   last_mday = 6'h30;
      default: last_mday = 6'h31;
    endcase
  end

  // --------------------------------------------------------------
  // Counter chain
  // --------------------------------------------------------------
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_sec   <= `RST_SECONDS;
      o_min   <= `RST_MINUTES;
      o_hour  <= `RST_HOURS;
      o_century_toggle_enable <= 1'b0;
      o_century_flag          <= 1'b0;
      o_wday  <= `RST_WEEKDAY;
      o_mday  <= `RST_DAY_OF_MONTH;
      o_month <= `RST_MONTH;
      o_year  <= `RST_YEAR;
    end
    else if (i_load)
    begin
      case (i_load_idx)
        `REG_SECONDS:      o_sec   <= i_load_data[6:0];
        `REG_MINUTES:      o_min   <= i_load_data[6:0];
        `REG_HOURS:
        begin
          o_century_toggle_enable <= i_load_data[`BIT_CENTURY_EN];
          o_century_flag          <= i_load_data[`BIT_CENTURY];
          o_hour <= i_load_data[5:0];
        end
        `REG_WEEKDAY:      o_wday  <= i_load_data[2:0];
        `REG_DAY_OF_MONTH: o_mday  <= i_load_data[5:0];
        `REG_MONTH:        o_month <= i_load_data[4:0];
        `REG_YEAR:         o_year  <= i_load_data;
        default:           o_sec   <= o_sec;
      endcase
    end
    else if (i_tick)
    begin
      // Packed BCD carry through all fields
      o_sec <= sec_end ? 7'h00 : sec_inc[6:0];
      if (sec_end)
        o_min <= min_end ? 7'h00 : min_inc[6:0];
      if (min_end)
        o_hour <= hour_end ? 6'h00 : hour_inc[5:0];
      if (hour_end)
      begin
        o_wday <= (o_wday == 3'h7) ? 3'h1 : o_wday + 3'h1;
        o_mday <= mday_end ? 6'h01 : mday_inc[5:0];
      end
      if (mday_end)
        o_month <= month_end ? 5'h01 : month_inc[4:0];
      if (month_end)
        o_year <= year_end ? 8'h00 : year_inc;
      if (year_end && o_century_toggle_enable)
        o_century_flag <= ~o_century_flag;
    end
  end

endmodule // bcd_calendar

/* File: sim/rtc_assertions.sv */
`timescale 1ns/10ps

module rtc_assertions
#(
  parameter HOLD_CYCLES     = 64,
  parameter OSC_LOSS_CYCLES = 64,
  parameter STARTUP_TICKS   = 2
)
(
  // Clock and reset
  input wire I_CLOCK,
  input wire I_RST,
  // Bus and pins
  input wire I_SCL,
  input wire I_SDA,
  input wire O_SDA,
  input wire O_SDA_OE,
  input wire I_OSC,
  input wire O_OUT,
  input wire O_OUT_OE
);
  // ----
  // Pin behaviour
  // ----
  default clocking cb_main @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RST);

  property p_sda_val; O_SDA_OE |-> !O_SDA; endproperty
  a_sda_val: assert property (p_sda_val) else $error("data pin driven high");
  property p_out_val; O_OUT_OE |-> !O_OUT; endproperty
  a_out_val: assert property (p_out_val) else $error("output pin driven high");
  property p_rst_quiet;
    disable iff (1'b0) I_RST && $past(I_RST) |-> !O_SDA_OE && !O_OUT_OE;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("pins pulled in reset");
  property p_oe_move; $changed(O_SDA_OE) |-> !I_SCL && !$past(I_SCL, 2); endproperty
  a_oe_move: assert property (p_oe_move) else $error("data moved near clock high");
  property p_oe_still; I_SCL && $past(I_SCL) |-> $stable(O_SDA_OE); endproperty
  a_oe_still: assert property (p_oe_still) else $error("data moved in clock high");
  property p_oe_hold; $rose(O_SDA_OE) |-> O_SDA_OE [*8]; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("low drive too short");
  property p_out_on_ack; $changed(O_OUT_OE) |-> O_SDA_OE && !$past(I_SCL); endproperty
  a_out_on_ack: assert property (p_out_on_ack) else $error("output moved off a write");
  property p_stop_free; I_SCL && $rose(I_SDA) |=> !O_SDA_OE; endproperty
  a_stop_free: assert property (p_stop_free) else $error("data held after stop");
endmodule // rtc_assertions

/* File: sim/two_wire_master.sv */
`timescale 1ns/10ps

module two_wire_master
#(
  parameter Q = 8
)
(
  // Clock and bus
  input  wire i_clk,
  input  wire i_sda,
  output reg  o_scl,
  output reg  o_sda
);
  // Bus idle, both lines released
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // Quarter bit time, then step off the edge
  task q;
    begin
      repeat (Q) @(posedge i_clk);
      #1;
    end
  endtask

  // One bit: data set in clock low, line sampled mid high
  task bit_io(input b, output r);
    begin
      o_sda = b;
      q;
      o_scl = 1'b1;
      q;
      r = i_sda;
      q;
      o_scl = 1'b0;
      q;
    end
  endtask

  // Start or repeated start
  task start;
    begin
      o_sda = 1'b1;
      q;
      o_scl = 1'b1;
      q;
      o_sda = 1'b0;
      q;
      o_scl = 1'b0;
      q;
    end
  endtask

  // Stop, leaving the bus idle
  task stop;
    begin
      o_sda = 1'b0;
      q;
      o_scl = 1'b1;
      q;
      o_sda = 1'b1;
      q;
    end
  endtask

  // Send a byte, report the slave acknowledge
  task wbyte(input [7:0] d, output ack);
    reg     r;
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
    end
  endtask

  // Take a byte, acknowledge it when ack is set
  task rbyte(input ack, output [7:0] d);
    reg     r;
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bit_io(1'b1, d[i]);
      bit_io(~ack, r);
    end
  endtask
endmodule // two_wire_master

/* File: sim/tb_top.sv */
`timescale 1ns/10ps

module tb_top;
  // ----
  // Bench signals
  // ----
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         osc = 1'b0;
  wire        scl;
  wire        m_sda;
  wire        sda_o;
  wire        sda_oe;
  wire        out_o;
  wire        out_oe;
  wire        sda_line;
  reg         ack;
  reg  [7:0]  wb [0:7];
  integer     fails = 0;
  integer     total_checks = 0;
  integer     osc_edges = 0;
  integer     i;

  // System clock and fast time base
  always #4 clk = ~clk;
  always @(posedge clk) #1 osc = ~osc;
  always @(posedge osc) if (!rst) osc_edges = osc_edges + 1;
  // Wired-AND data line with pull-up
  assign sda_line = m_sda & (sda_oe ? sda_o : 1'b1);

  serial_bcd_rtc_core #(.HOLD_CYCLES(64), .OSC_LOSS_CYCLES(64), .STARTUP_TICKS(2)) i_dut (
    .I_CLOCK(clk), .I_RST(rst), .I_SCL(scl), .I_SDA(sda_line), .O_SDA(sda_o),
    .O_SDA_OE(sda_oe), .I_OSC(osc), .O_OUT(out_o), .O_OUT_OE(out_oe));
  two_wire_master #(.Q(2)) i_master (.i_clk(clk), .i_sda(sda_line), .o_scl(scl), .o_sda(m_sda));

  // Compare and count
  task chk(input string name, input [7:0] seen, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp)
      begin
        fails = fails + 1;
        $display("[FAIL] %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask

  // Write n bytes of wb from pointer p
  task wr(input [7:0] p, input integer n);
    integer k;
    begin
      i_master.start;
      i_master.wbyte(8'hd0, ack);
      chk("addr ack", {7'h00, ack}, 8'h01);
      i_master.wbyte(p, ack);
      chk("ptr ack", {7'h00, ack}, 8'h01);
      for (k = 0; k < n; k = k + 1)
      begin
        i_master.wbyte(wb[k], ack);
        chk("data ack", {7'h00, ack}, 8'h01);
      end
      i_master.stop;
    end
  endtask

  // Read n bytes, optionally setting the pointer first, against e
  task rdchk(input setp, input [7:0] p, input integer n, input [63:0] e);
    integer     k;
    reg  [7:0]  v;
    begin
      if (setp)
      begin
        i_master.start;
        i_master.wbyte(8'hd0, ack);
        i_master.wbyte(p, ack);
      end
      i_master.start;
      i_master.wbyte(8'hd1, ack);
      chk("read ack", {7'h00, ack}, 8'h01);
      for (k = 0; k < n; k = k + 1)
      begin
        i_master.rbyte(k < n - 1, v);
        chk("read data", v, e[63 - 8 * k -: 8]);
      end
      i_master.stop;
    end
  endtask

  // Verdict
  task close_out;
    begin
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("out drive", {7'h00, out_oe}, 8'h00);
    rdchk(1'b1, 8'h00, 8, 64'h0080_0001_0101_0080);
    i_master.start;
    i_master.wbyte(8'ha0, ack);
    chk("foreign ack", {7'h00, ack}, 8'h00);
    i_master.stop;
    wb[0] = 8'h00;
    wr(8'h07, 1);
    chk("out low", {7'h00, out_oe}, 8'h01);
    rdchk(1'b1, 8'h07, 1, 64'h0);
    {wb[0], wb[1], wb[2], wb[3], wb[4], wb[5], wb[6], wb[7]} = 64'h59a3_0731_1299_8059;
    wr(8'h01, 8);
    chk("out released", {7'h00, out_oe}, 8'h00);
    rdchk(1'b1, 8'h00, 8, 64'h5959_a307_3112_9980);
    rdchk(1'b1, 8'h02, 1, 64'ha300_0000_0000_0000);
    rdchk(1'b0, 8'h00, 2, 64'ha307_0000_0000_0000);
    rdchk(1'b0, 8'h00, 1, 64'h0700_0000_0000_0000);
    // Let the first second elapse, bounded
    for (i = 0; i < 70000 && osc_edges < 32788; i = i + 1)
      @(posedge clk);
    chk("second elapsed", {7'h00, osc_edges >= 32788}, 8'h01);
    rdchk(1'b1, 8'h00, 8, 64'h0000_c001_0101_0080);
    wb[0] = 8'h80;
    wr(8'h00, 1);
    wb[0] = 8'h00;
    wr(8'h01, 1);
    rdchk(1'b1, 8'h00, 2, 64'h8080_0000_0000_0000);
    close_out;
  end
endmodule // tb_top

bind serial_bcd_rtc_core rtc_assertions #(
  .HOLD_CYCLES(HOLD_CYCLES), .OSC_LOSS_CYCLES(OSC_LOSS_CYCLES), .STARTUP_TICKS(STARTUP_TICKS)
) i_chk (
  .I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_SCL(I_SCL), .I_SDA(I_SDA), .O_SDA(O_SDA),
  .O_SDA_OE(O_SDA_OE), .I_OSC(I_OSC), .O_OUT(O_OUT), .O_OUT_OE(O_OUT_OE)
);
